/* logic/boot_cfg_pkg.sv */
// constants, types and bit layout of the boot configuration block
// Contract
// - reset pin release loads config from 00FFF9h
// - test pin low fetches from internal ROM
// - test pin high fetches from external memory
// - reset pulse 4095 or 16 oscillator periods
// - test high first pulse short, low always long
// - pin mode from mode bit, toggle, test pin
// - bus quiet bit floats bus on internal access
// - ROM enable and disable bits select program storage
// - RAM and CPU enable bits gate on-chip blocks
// - fixed on-chip address map for five regions
// - unbacked addresses go external, internal wins overlap
// - disabled RAM, ROM, text RAM decode external
// - static RAM keeps contents through any reset
package boot_cfg_pkg;
  // -------------------------------------------------------
  // address map
  // -------------------------------------------------------
  localparam logic [23:0] CTRL_WORD_ADDR = 24'h00fff9; // control word
  localparam logic [23:0] PRAM_HI = 24'h000fff; // program RAM top
  localparam logic [23:0] IO_LO = 24'h001e00; // i/o registers
  localparam logic [23:0] IO_HI = 24'h001fff;
  localparam logic [23:0] BOOT_LO = 24'h002000; // boot ROM
  localparam logic [23:0] BOOT_HI = 24'h0023ff;
  localparam logic [23:0] PROM_LO = 24'h002400; // program ROM
  localparam logic [23:0] PROM_HI = 24'h019fff;
  localparam logic [23:0] TRAM_LO = 24'h0a0000; // text RAM
  localparam logic [23:0] TRAM_HI = 24'h0a3fff;
  // -------------------------------------------------------
  // configuration register fields
  // -------------------------------------------------------
  localparam int BIT_PULSE_LONG = 7; // reset_pulse_long
  localparam int BIT_TOGGLE = 6; // strap_pin_toggle_enable
  localparam int BIT_QUIET = 5; // ext_bus_quiet_on_internal
  localparam int BIT_MF_NORMAL = 4; // multifunction_pin_normal
  localparam int BIT_FROM_DIS = 3; // factory_rom_disable
  localparam int BIT_ROM_EN = 2; // onchip_rom_enable
  localparam int BIT_RAM_EN = 1; // onchip_ram_enable
  localparam int BIT_CPU_EN = 0; // onchip_cpu_enable
  localparam logic [7:0] CFG_RST = 8'hff; // value before first fetch
  // -------------------------------------------------------
  // apb offsets and timing
  // -------------------------------------------------------
  localparam logic [11:0] OFS_CONFIG = 12'h000; // system_config
  localparam logic [11:0] OFS_STATUS = 12'h004; // boot status
  localparam logic [11:0] PULSE_LONG_CYC = 12'hfff; // 4095 periods
  localparam logic [11:0] PULSE_SHORT_CYC = 12'h010; // 16 periods
  // -------------------------------------------------------
  // types
  // -------------------------------------------------------
  typedef enum logic [2:0] {RG_EXT, RG_PRAM, RG_IO, RG_BOOT, RG_PROM, RG_TRAM} region_e;
  typedef enum logic [1:0] {SRC_CPU_ROM, SRC_TEST_ROM, SRC_EXT} src_e;
  typedef enum logic [1:0] {ST_HOLD = 2'b00, ST_FETCH = 2'b01, ST_RUN = 2'b11} boot_e;
endpackage

/* logic/decode_if.sv */
// interface between the top and the address decoder
`timescale 1ns/1ps
`default_nettype none
interface decode_if;
  logic [23:0] addr; // cpu address
  logic ram_en; // program RAM enabled
  logic rom_en; // program ROM enabled
  logic tram_en; // text RAM out of standby
  boot_cfg_pkg::region_e region; // decoded target
  modport req (output addr, ram_en, rom_en, tram_en, input region);
  modport dec (input addr, ram_en, rom_en, tram_en, output region);
endinterface
`default_nettype wire

/* logic/addr_decode.sv */
// combinational decoder of cpu addresses into on-chip regions
`timescale 1ns/1ps
`default_nettype none
module addr_decode (
  decode_if.dec d // address in, region out
);
  // -------------------------------------------------------
  // region select, internal segments first
  // -------------------------------------------------------
  always_comb begin
    d.region = boot_cfg_pkg::RG_EXT;
    if (d.addr <= boot_cfg_pkg::PRAM_HI && d.ram_en) begin
      d.region = boot_cfg_pkg::RG_PRAM;
    end else if (d.addr >= boot_cfg_pkg::IO_LO && d.addr <= boot_cfg_pkg::IO_HI) begin
      d.region = boot_cfg_pkg::RG_IO;
    end else if (d.addr >= boot_cfg_pkg::BOOT_LO && d.addr <= boot_cfg_pkg::BOOT_HI && d.rom_en) begin
      d.region = boot_cfg_pkg::RG_BOOT;
    end else if (d.addr >= boot_cfg_pkg::PROM_LO && d.addr <= boot_cfg_pkg::PROM_HI && d.rom_en) begin
      d.region = boot_cfg_pkg::RG_PROM;
    end else if (d.addr >= boot_cfg_pkg::TRAM_LO && d.addr <= boot_cfg_pkg::TRAM_HI && d.tram_en) begin
      d.region = boot_cfg_pkg::RG_TRAM;
    end
  end
endmodule
`default_nettype wire

/* logic/reset_pulse.sv */
// timer that holds the reset pin low for a long or short pulse
`timescale 1ns/1ps
`default_nettype none
module reset_pulse (
  input wire logic clk_in, // oscillator clock
  input wire logic rst_in, // async reset, high
  input wire logic start_in, // begin a pulse
  input wire logic long_in, // long pulse when high
  output logic active_out // pulse running
);
  logic [11:0] cnt_q; // cycles left
  logic [11:0] cnt_d;
  logic active_q;
  logic active_d;
  logic long_q; // helper: length of running pulse
  logic long_d;
  logic [11:0] len_q; // helper: cycles seen so far
  logic [11:0] len_d;
  // -------------------------------------------------------
  // next-state of the countdown
  // -------------------------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    active_d = active_q;
    long_d = long_q;
    len_d = active_q ? len_q + 12'h001 : 12'h000;
    if (start_in && !active_q) begin // load length
      cnt_d = long_in ? boot_cfg_pkg::PULSE_LONG_CYC : boot_cfg_pkg::PULSE_SHORT_CYC;
      active_d = 1'b1;
      long_d = long_in;
    end else if (active_q) begin // count down
      cnt_d = cnt_q - 12'h001;
      if (cnt_q == 12'h001) begin
        active_d = 1'b0;
      end
    end
  end
  // -------------------------------------------------------
  // registers
  // -------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 12'h000;
      active_q <= 1'b0;
      long_q <= 1'b0;
      len_q <= 12'h000;
    end else begin
      cnt_q <= cnt_d;
      active_q <= active_d;
      long_q <= long_d;
      len_q <= len_d;
    end
  end
  assign active_out = active_q;
  // -------------------------------------------------------
  // checks
  // -------------------------------------------------------
  property p_pulse_len;
    @(posedge clk_in) disable iff (rst_in)
    $fell(active_q) |-> len_q == (long_q ? boot_cfg_pkg::PULSE_LONG_CYC : boot_cfg_pkg::PULSE_SHORT_CYC);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");
endmodule
`default_nettype wire

/* logic/boot_config_top.sv */
// boot configuration loader, config register and memory decode
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module boot_config_top (
  input wire logic SYS_CLK_IN, // oscillator clock, 250 MHz
  input wire logic RST_IN, // power-on reset, async high
  input wire logic PSEL_IN, // apb select
  input wire logic PENABLE_IN, // apb enable
  input wire logic PWRITE_IN, // apb direction
  input wire logic [11:0] PADDR_IN, // apb byte address
  input wire logic [31:0] PWDATA_IN, // apb write data
  output logic [31:0] PRDATA_OUT, // apb read data
  output logic PREADY_OUT, // apb ready
  output logic PSLVERR_OUT, // apb error
  input wire logic RESET_PIN_IN, // reset pin level
  output logic RESET_PIN_OUT, // reset pin value, always low
  output logic RESET_PIN_OE_N_OUT, // low while pulling pin low
  input wire logic TEST_PIN_IN, // test strap pin
  input wire logic INT_RESET_REQ_IN, // internal reset source
  output logic FETCH_REQ_OUT, // control word read request
  output logic FETCH_EXT_OUT, // read from external memory
  output logic [23:0] FETCH_ADDR_OUT, // control word address
  input wire logic FETCH_ACK_IN, // control word valid
  input wire logic [7:0] FETCH_DATA_IN, // control word
  input wire logic CPU_ACC_IN, // cpu memory access
  input wire logic CPU_WR_IN, // cpu write
  input wire logic [23:0] CPU_ADDR_IN, // cpu address
  input wire logic TEXT_RAM_ON_IN, // text RAM standby control
  output logic [2:0] REGION_OUT, // decoded region
  output logic EXT_SEL_OUT, // access goes external
  output logic EXT_BUS_OE_N_OUT, // low drives data and strobes
  output logic EXT_WRITE_STROBE_N_OUT, // external write strobe
  output logic EXT_OUTPUT_ENABLE_N_OUT, // external read strobe
  output logic MF_PIN_NORMAL_OUT, // multi-function pins normal
  output logic [1:0] PROG_SRC_OUT, // program storage source
  output logic ONCHIP_RAM_EN_OUT, // on-chip RAM enable
  output logic ONCHIP_CPU_EN_OUT, // on-chip CPU enable
  output logic CPU_HOLD_OUT // cpu held until config loaded
);
  // -------------------------------------------------------
  // declarations
  // -------------------------------------------------------
  logic rpin_m_q; // reset pin sync stage 1
  logic rpin_s_q; // reset pin sync stage 2
  logic test_m_q; // test pin sync stage 1
  logic test_s_q; // test pin sync stage 2
  boot_cfg_pkg::boot_e st_q; // boot state
  boot_cfg_pkg::boot_e st_d;
  logic [7:0] cfg_q; // system_config
  logic [7:0] cfg_d;
  logic strap_q; // test pin caught at release
  logic strap_d;
  logic first_done_q; // a pulse since power-on
  logic first_done_d;
  logic fetch_req_q;
  logic fetch_req_d;
  logic hold_q; // cpu held until config loaded
  logic hold_d;
  logic pulse_active; // reset pulse running
  logic pulse_start; // start a pulse
  logic pulse_long; // chosen length
  logic apb_access; // access phase, not yet ready
  logic apb_fire; // transfer completes this edge
  logic cfg_wr; // software write to config
  logic [31:0] prdata_d;
  logic pready_d;
  logic pslverr_d;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic internal_acc; // access hits an on-chip region
  logic [2:0] region_d;
  logic ext_sel_d;
  logic bus_oe_n_d;
  logic wr_n_d;
  logic oe_n_d;
  logic mf_d;
  logic [1:0] src_d;
  logic [2:0] region_q;
  logic ext_sel_q;
  logic bus_oe_n_q;
  logic wr_n_q;
  logic oe_n_q;
  logic mf_q;
  logic [1:0] src_q;
  logic ram_en_q;
  logic cpu_en_q;
  decode_if dif ();
  // -------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rpin_m_q <= 1'b0;
      rpin_s_q <= 1'b0;
      test_m_q <= 1'b0;
      test_s_q <= 1'b0;
    end else begin
      rpin_m_q <= RESET_PIN_IN;
      rpin_s_q <= rpin_m_q;
      test_m_q <= TEST_PIN_IN;
      test_s_q <= test_m_q;
    end
  end
  // -------------------------------------------------------
  // reset pulse on the pin
  // -------------------------------------------------------
  assign pulse_start = INT_RESET_REQ_IN && !pulse_active;
  // short first pulse with test high, long always with test low
  assign pulse_long = !test_s_q || (first_done_q && cfg_q[boot_cfg_pkg::BIT_PULSE_LONG]);
  reset_pulse i_reset_pulse (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .start_in(pulse_start),
    .long_in(pulse_long),
    .active_out(pulse_active)
  );
  assign RESET_PIN_OUT = 1'b0; // open drain, only pulls low
  assign RESET_PIN_OE_N_OUT = !pulse_active;
  // -------------------------------------------------------
  // apb decode
  // -------------------------------------------------------
  assign apb_access = PSEL_IN && PENABLE_IN && !pready_q;
  assign apb_fire = PSEL_IN && PENABLE_IN && pready_q;
  assign cfg_wr = apb_fire && PWRITE_IN && PADDR_IN == boot_cfg_pkg::OFS_CONFIG;
  // -------------------------------------------------------
  // boot state machine and config register, next state
  // -------------------------------------------------------
  always_comb begin
    st_d = st_q;
    cfg_d = cfg_q;
    strap_d = strap_q;
    first_done_d = first_done_q || pulse_start;
    unique case (st_q)
      boot_cfg_pkg::ST_HOLD: begin // wait for pin release
        if (rpin_s_q) begin
          st_d = boot_cfg_pkg::ST_FETCH;
          strap_d = test_s_q;
        end
      end
      boot_cfg_pkg::ST_FETCH: begin // read control word
        if (FETCH_ACK_IN) begin
          cfg_d = FETCH_DATA_IN;
          st_d = boot_cfg_pkg::ST_RUN;
        end
      end
      boot_cfg_pkg::ST_RUN: begin // normal operation
        if (cfg_wr) begin
          cfg_d = PWDATA_IN[7:0];
        end
      end
      default: begin // illegal code
        st_d = boot_cfg_pkg::ST_HOLD;
      end
    endcase
    if (!rpin_s_q) begin // pin low restarts the load
      st_d = boot_cfg_pkg::ST_HOLD;
    end
    fetch_req_d = st_d == boot_cfg_pkg::ST_FETCH;
    hold_d = st_d != boot_cfg_pkg::ST_RUN;
  end
  // -------------------------------------------------------
  // boot state machine registers
  // -------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      st_q <= boot_cfg_pkg::ST_HOLD;
      cfg_q <= boot_cfg_pkg::CFG_RST;
      strap_q <= 1'b0;
      first_done_q <= 1'b0;
      fetch_req_q <= 1'b0;
      hold_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cfg_q <= cfg_d;
      strap_q <= strap_d;
      first_done_q <= first_done_d;
      fetch_req_q <= fetch_req_d;
      hold_q <= hold_d;
    end
  end
  assign FETCH_REQ_OUT = fetch_req_q;
  assign FETCH_EXT_OUT = strap_q;
  assign FETCH_ADDR_OUT = boot_cfg_pkg::CTRL_WORD_ADDR;
  assign CPU_HOLD_OUT = hold_q;
  // -------------------------------------------------------
  // apb slave, next values
  // -------------------------------------------------------
  always_comb begin
    pready_d = apb_access; // one wait state
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    if (apb_access) begin
      prdata_d = 32'h00000000;
      if (PADDR_IN == boot_cfg_pkg::OFS_CONFIG) begin // config
        prdata_d[7:0] = cfg_q;
      end else if (PADDR_IN == boot_cfg_pkg::OFS_STATUS) begin // status
        prdata_d[5:0] = {pulse_active, first_done_q, mf_q, strap_q, st_q};
      end else begin // unmapped
        pslverr_d = 1'b1;
      end
    end
  end
  // -------------------------------------------------------
  // apb slave registers
  // -------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end
  assign PRDATA_OUT = prdata_q;
  assign PREADY_OUT = pready_q;
  assign PSLVERR_OUT = pslverr_q;
  // -------------------------------------------------------
  // address decode and bus control, next values
  // -------------------------------------------------------
  assign dif.addr = CPU_ADDR_IN;
  assign dif.ram_en = cfg_q[boot_cfg_pkg::BIT_RAM_EN];
  assign dif.rom_en = cfg_q[boot_cfg_pkg::BIT_ROM_EN];
  assign dif.tram_en = TEXT_RAM_ON_IN;
  addr_decode i_addr_decode (
    .d(dif.dec)
  );
  assign internal_acc = dif.region != boot_cfg_pkg::RG_EXT;
  always_comb begin
    region_d = region_q;
    ext_sel_d = 1'b0;
    bus_oe_n_d = 1'b0; // bus driven by default
    wr_n_d = 1'b1;
    oe_n_d = 1'b1;
    if (CPU_ACC_IN) begin // live access
      region_d = dif.region;
      ext_sel_d = !internal_acc;
      bus_oe_n_d = internal_acc && cfg_q[boot_cfg_pkg::BIT_QUIET];
      wr_n_d = internal_acc || !CPU_WR_IN;
      oe_n_d = internal_acc || CPU_WR_IN;
    end
    mf_d = cfg_q[boot_cfg_pkg::BIT_MF_NORMAL] || (cfg_q[boot_cfg_pkg::BIT_TOGGLE] && test_s_q);
    if (!cfg_q[boot_cfg_pkg::BIT_ROM_EN]) begin
      src_d = boot_cfg_pkg::SRC_EXT;
    end else if (cfg_q[boot_cfg_pkg::BIT_FROM_DIS]) begin
      src_d = boot_cfg_pkg::SRC_CPU_ROM;
    end else begin
      src_d = boot_cfg_pkg::SRC_TEST_ROM;
    end
  end
  // -------------------------------------------------------
  // decode and pin-mode registers; RAM contents never cleared here
  // -------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      region_q <= boot_cfg_pkg::RG_EXT;
      ext_sel_q <= 1'b0;
      bus_oe_n_q <= 1'b0;
      wr_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      mf_q <= 1'b1;
      src_q <= boot_cfg_pkg::SRC_CPU_ROM;
      ram_en_q <= 1'b1;
      cpu_en_q <= 1'b1;
    end else begin
      region_q <= region_d;
      ext_sel_q <= ext_sel_d;
      bus_oe_n_q <= bus_oe_n_d;
      wr_n_q <= wr_n_d;
      oe_n_q <= oe_n_d;
      mf_q <= mf_d;
      src_q <= src_d;
      ram_en_q <= cfg_q[boot_cfg_pkg::BIT_RAM_EN];
      cpu_en_q <= cfg_q[boot_cfg_pkg::BIT_CPU_EN];
    end
  end
  assign REGION_OUT = region_q;
  assign EXT_SEL_OUT = ext_sel_q;
  assign EXT_BUS_OE_N_OUT = bus_oe_n_q;
  assign EXT_WRITE_STROBE_N_OUT = wr_n_q;
  assign EXT_OUTPUT_ENABLE_N_OUT = oe_n_q;
  assign MF_PIN_NORMAL_OUT = mf_q;
  assign PROG_SRC_OUT = src_q;
  assign ONCHIP_RAM_EN_OUT = ram_en_q;
  assign ONCHIP_CPU_EN_OUT = cpu_en_q;
  // -------------------------------------------------------
  // checks
  // -------------------------------------------------------
  property p_release_fetch;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    (st_q == boot_cfg_pkg::ST_HOLD && rpin_s_q) |=> (st_q == boot_cfg_pkg::ST_FETCH && FETCH_REQ_OUT);
  endproperty
  a_release_fetch: assert property (p_release_fetch) else $error("no fetch after release");
  property p_fetch_int;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    (st_q == boot_cfg_pkg::ST_HOLD && rpin_s_q && !test_s_q) |=> !FETCH_EXT_OUT;
  endproperty
  a_fetch_int: assert property (p_fetch_int) else $error("fetch not internal");
  property p_fetch_load;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    (st_q == boot_cfg_pkg::ST_FETCH && FETCH_ACK_IN && rpin_s_q) |=> cfg_q == $past(FETCH_DATA_IN);
  endproperty
  a_fetch_load: assert property (p_fetch_load) else $error("control word not loaded");
  property p_long_when_low;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    (pulse_start && !test_s_q) |-> pulse_long;
  endproperty
  a_long_when_low: assert property (p_long_when_low) else $error("short pulse with test low");
  property p_mf_mode;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    ##1 MF_PIN_NORMAL_OUT == ($past(cfg_q[4]) || ($past(cfg_q[6]) && $past(test_s_q)));
  endproperty
  a_mf_mode: assert property (p_mf_mode) else $error("pin mode wrong");
  property p_quiet;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    (CPU_ACC_IN && internal_acc && cfg_q[boot_cfg_pkg::BIT_QUIET]) |=> EXT_BUS_OE_N_OUT && !EXT_SEL_OUT;
  endproperty
  a_quiet: assert property (p_quiet) else $error("bus not floated");
  property p_src;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    !cfg_q[boot_cfg_pkg::BIT_ROM_EN] |=> PROG_SRC_OUT == boot_cfg_pkg::SRC_EXT;
  endproperty
  a_src: assert property (p_src) else $error("storage not external");
  property p_pram;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    (CPU_ACC_IN && CPU_ADDR_IN <= 24'h000fff) |=> REGION_OUT == ($past(cfg_q[1]) ? 3'h1 : 3'h0);
  endproperty
  a_pram: assert property (p_pram) else $error("program RAM decode wrong");
  property p_sw_write;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    (cfg_wr && st_q == boot_cfg_pkg::ST_RUN && rpin_s_q) |=> ##1 ONCHIP_CPU_EN_OUT == $past(PWDATA_IN[0], 2);
  endproperty
  a_sw_write: assert property (p_sw_write) else $error("config write lost");
endmodule
`default_nettype wire

/* testbench/ext_prog_mem.sv */
// far-side memory model answering control word fetches
`timescale 1ns/1ps
`default_nettype none
module ext_prog_mem (
  input wire logic clk_in, // oscillator clock
  input wire logic rst_in, // async reset, high
  input wire logic req_in, // fetch request
  input wire logic ext_in, // external memory chosen
  input wire logic [23:0] addr_in, // fetch address
  input wire logic [7:0] rom_word_in, // mask ROM word
  input wire logic [7:0] ext_word_in, // external word
  output logic ack_out, // word valid pulse
  output logic [7:0] data_out // fetched word
);
  logic [1:0] cnt_q; // wait counter
  // mask ROM answers at once, external memory three cycles late
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 2'h0;
      ack_out <= 1'b0;
      data_out <= 8'h00;
    end else if (req_in && !ack_out && cnt_q == (ext_in ? 2'h3 : 2'h0)) begin
      cnt_q <= 2'h0;
      ack_out <= 1'b1;
      data_out <= (addr_in === 24'h00fff9) ? (ext_in ? ext_word_in : rom_word_in) : 8'h00;
    end else begin
      cnt_q <= req_in && !ack_out ? cnt_q + 2'h1 : 2'h0;
      ack_out <= 1'b0;
      data_out <= ~data_out; // data lines not held after the answer
    end
  end
endmodule
`default_nettype wire

/* testbench/boot_config_and_memory_decode_tb_top.sv */
// self-checking bench for the boot configuration block
`timescale 1ns/1ps
`default_nettype none
module boot_config_and_memory_decode_tb_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk, rst, psel, pen, pwr, pin_drv, test, intreq, ack, acc, tram_on, err, cwr;
  logic pready, pslverr, rp_out, rp_oe_n, fetch_req, fetch_ext, ext_sel, bus_oe_n, oen, wrn, mf, ram_en, cpu_en, hold;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] fetch_addr, caddr;
  logic [7:0] fdata, cfg_now;
  logic [2:0] region;
  logic [1:0] src;
  int n_fail = 0;
  int compares = 0;
  wire logic pin = pin_drv & rp_oe_n; // wired open-drain reset line
  boot_config_top i_boot_config_top (.SYS_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .RESET_PIN_IN(pin), .RESET_PIN_OUT(rp_out), .RESET_PIN_OE_N_OUT(rp_oe_n),
    .TEST_PIN_IN(test), .INT_RESET_REQ_IN(intreq), .FETCH_REQ_OUT(fetch_req), .FETCH_EXT_OUT(fetch_ext),
    .FETCH_ADDR_OUT(fetch_addr), .FETCH_ACK_IN(ack), .FETCH_DATA_IN(fdata), .CPU_ACC_IN(acc), .CPU_WR_IN(cwr),
    .CPU_ADDR_IN(caddr), .TEXT_RAM_ON_IN(tram_on), .REGION_OUT(region), .EXT_SEL_OUT(ext_sel),
    .EXT_BUS_OE_N_OUT(bus_oe_n), .EXT_WRITE_STROBE_N_OUT(wrn), .EXT_OUTPUT_ENABLE_N_OUT(oen),
    .MF_PIN_NORMAL_OUT(mf), .PROG_SRC_OUT(src), .ONCHIP_RAM_EN_OUT(ram_en), .ONCHIP_CPU_EN_OUT(cpu_en),
    .CPU_HOLD_OUT(hold));
  // stand-alone word in mask ROM, bus-mode word in external memory
  ext_prog_mem i_ext_prog_mem (.clk_in(clk), .rst_in(rst), .req_in(fetch_req), .ext_in(fetch_ext),
    .addr_in(fetch_addr), .rom_word_in(8'hff), .ext_word_in(8'hab), .ack_out(ack), .data_out(fdata));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wcfg(input logic [7:0] v);
    apb(1'b1, 12'h000, v);
    cfg_now = v;
    repeat (2) @(posedge clk);
  endtask
  task automatic wait_run();
    int g = 0;
    while (hold !== 1'b0 && g < 60) begin
      @(posedge clk);
      g++;
    end
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic boot(input logic lvl, input logic [7:0] w);
    @(posedge clk);
    test <= lvl;
    pin_drv <= 1'b0;
    repeat (5) @(posedge clk);
    pin_drv <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk(fetch_ext, lvl);
    chk(fetch_addr, 24'h00fff9);
    wait_run();
    apb(1'b0, 12'h000, 8'h00);
    chk(rd, w);
    cfg_now = w;
  endtask
  task automatic pulse(input int len);
    int g = 0;
    int n = 0;
    @(posedge clk);
    intreq <= 1'b1;
    @(posedge clk);
    intreq <= 1'b0;
    #1;
    while (rp_oe_n === 1'b0 && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n, len);
    wait_run();
  endtask
  task automatic dec(input logic [23:0] a, input logic [2:0] e, input logic w = 1'b0);
    @(posedge clk);
    acc <= 1'b1;
    cwr <= w;
    caddr <= a;
    @(posedge clk);
    acc <= 1'b0;
    #1;
    chk(region, e);
    chk(ext_sel, e == 3'h0);
    chk(bus_oe_n, e != 3'h0 && cfg_now[5]);
    chk(oen, e != 3'h0 || w);
    chk(wrn, e != 3'h0 || !w);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_boot_pulses();
    boot(1'b1, 8'hab);
    chk({mf, src, ram_en, cpu_en}, 5'b01011);
    pulse(16);
    pulse(4095);
    boot(1'b0, 8'hff);
    wcfg(8'h7f);
    pulse(4095);
  endtask
  task automatic t_fields();
    logic [7:0] cv [5] = '{8'hff, 8'hf7, 8'hfb, 8'hfc, 8'h47};
    logic [4:0] ex [5] = '{5'b10011, 5'b10111, 5'b11011, 5'b10000, 5'b00111};
    for (int i = 0; i < 5; i++) begin
      wcfg(cv[i]);
      #1;
      chk({mf, src, ram_en, cpu_en}, ex[i]);
    end
    @(posedge clk);
    test <= 1'b1;
    repeat (6) @(posedge clk);
    chk(mf, 1'b1);
    wcfg(8'h07);
    chk(mf, 1'b0);
    apb(1'b1, 12'h008, 8'h00);
    chk(err, 1'b1);
    apb(1'b0, 12'h000, 8'h00);
    chk(rd, 32'h07);
  endtask
  task automatic t_decode();
    logic [23:0] ad [11] = '{24'h000fff, 24'h001000, 24'h001e00, 24'h002000, 24'h0023ff, 24'h002400,
      24'h019fff, 24'h01a000, 24'h0a0000, 24'h0a3fff, 24'h0a4000};
    logic [2:0] rg [11] = '{3'h1, 3'h0, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4, 3'h0, 3'h5, 3'h5, 3'h0};
    wcfg(8'hff);
    for (int i = 0; i < 11; i++) dec(ad[i], rg[i]);
    wcfg(8'hfd);
    dec(24'h000000, 3'h0);
    wcfg(8'hfb);
    dec(24'h002400, 3'h0);
    dec(24'h002400, 3'h0, 1'b1);
    dec(24'h000000, 3'h1, 1'b1);
    wcfg(8'hdf);
    tram_on <= 1'b0;
    dec(24'h000000, 3'h1);
    dec(24'h0a0000, 3'h0);
  endtask
  task automatic print_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // reset, then scenarios in order
  initial begin
    {rst, psel, pen, pwr, pin_drv, intreq, acc, cwr} = 8'h80;
    {test, tram_on, paddr, pwdata, caddr, cfg_now} = '1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 12'h000, 8'h00);
    chk(rd, 32'hff);
    t_boot_pulses();
    t_fields();
    t_decode();
    print_verdict();
  end
  // watchdog against a hang
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire
